// >>> dcd_busy_peer.sv
// Second device on the shared busy wire, pulling it low on request.
module dcd_busy_peer (
	input wire logic ref_clk,
	input wire logic hold_go,
	input wire logic [7:0] hold_len,
	output logic pull_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r = 8'h00;
	always @(posedge ref_clk) begin
		if (hold_go)
			cnt_r <= hold_len;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
	assign pull_oe = (cnt_r != 8'h00);
endmodule

// >>> dcd_cal_unit.sv
// Shared gain and offset arithmetic with saturation.
module dcd_cal_unit (
	input wire logic [dcd_pkg::CODE_W-1:0] in_code,
	input wire logic [dcd_pkg::CODE_W-1:0] gain_code,
	input wire logic [dcd_pkg::CODE_W-1:0] off_code,
	output logic [dcd_pkg::CODE_W-1:0] cal_code
);
	localparam int W = dcd_pkg::CODE_W;
	localparam logic signed [W+2:0] HALF = (W + 3)'(1) << (W - 1);
	localparam logic signed [W+2:0] TOP = {3'h0, {W{1'b1}}};
	logic [2*W:0] prod;
	logic [W:0] scaled;
	logic signed [W+2:0] sum;
	logic under;
	logic over;

	// Input times (gain + 1), scaled down by two to the code width.
	assign prod = (2 * W + 1)'(in_code) *
		((2 * W + 1)'(gain_code) + (2 * W + 1)'(1));
	assign scaled = prod[2*W:W];
	assign sum = $signed({2'h0, scaled}) + $signed({3'h0, off_code}) - HALF;
	assign under = sum < 0;
	assign over = sum > TOP;
	// Out-of-range results clip to the nearest end of the code range.
	assign cal_code = under ? '0 : (over ? '1 : sum[W-1:0]);
endmodule

// >>> dcd_datapath.sv
// Top of the DAC channel calibration datapath: registers, sequencer, load.
module dcd_datapath #(
	parameter int INIT_CYCLES = dcd_pkg::INIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [dcd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dcd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dcd_pkg::DATA_W-1:0] reg_rdata,
	input wire logic load_strobe_n,
	input wire logic clear_n,
	input wire logic busy_n_i,
	output logic busy_n_o,
	output logic busy_n_oe,
	output logic [dcd_pkg::CH_N*dcd_pkg::CODE_W-1:0] dac_code,
	output logic [dcd_pkg::CH_N*dcd_pkg::LVL_W-1:0] out_level,
	output logic out_drive,
	output logic [dcd_pkg::OFS_W-1:0] group0_offset_code,
	output logic [dcd_pkg::OFS_W-1:0] group1_offset_code
);
	localparam int N = dcd_pkg::CH_N;
	localparam int W = dcd_pkg::CODE_W;
	localparam int G = dcd_pkg::GRP_N;
	localparam int DW = dcd_pkg::DATA_W;

	// Channel storage; the calibrated and DAC arrays have no bus path.
	logic [W-1:0] input_bank_a [N];
	logic [W-1:0] input_bank_b [N];
	logic [W-1:0] gain_r [N];
	logic [W-1:0] offset_r [N];
	logic [W-1:0] calibrated_bank_a [N];
	logic [W-1:0] calibrated_bank_b [N];
	logic [W-1:0] dac_r [N];

	logic bank_r;
	logic [G-1:0] group0_source_select;
	logic [G-1:0] group1_source_select;
	logic [dcd_pkg::OFS_W-1:0] ofs0_r;
	logic [dcd_pkg::OFS_W-1:0] ofs1_r;
	logic [dcd_pkg::SEL_CNT_W-1:0] sel_cnt_r;
	logic [N-1:0] pend_a_r;
	logic [N-1:0] pend_b_r;
	logic [N-1:0] pend_a_nxt;
	logic [N-1:0] pend_b_nxt;
	logic [N-1:0] chg_a_r;
	logic [N-1:0] chg_b_r;
	logic load_pend_r;
	logic load_pend_nxt;
	dcd_pkg::dcd_seq_t state_r;
	logic [dcd_pkg::CH_W-1:0] op_ch_r;
	logic op_bank_r;
	logic [W-1:0] op_in_r;
	logic [W-1:0] op_gain_r;
	logic [W-1:0] op_off_r;
	logic [W-1:0] res_r;
	logic [W-1:0] cal_out;
	logic [DW-1:0] reg_rdata_r;

	// Pin synchronisers, bits {busy, clear, load}.
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_s3_r;
	logic [2:0] pin_lvl_r;
	logic [2:0] pin_agree;
	logic [2:0] pin_lvl_nxt;
	logic load_fall;
	logic clear_ok;
	logic ext_busy;
	logic init_done;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_s1_r <= dcd_pkg::PIN_IDLE;
			pin_s2_r <= dcd_pkg::PIN_IDLE;
			pin_s3_r <= dcd_pkg::PIN_IDLE;
			pin_lvl_r <= dcd_pkg::PIN_IDLE;
		end else begin
			pin_s1_r <= {busy_n_i, clear_n, load_strobe_n};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_lvl_r <= pin_lvl_nxt;
		end
	end

	assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
	assign pin_lvl_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_lvl_r);
	assign load_fall = pin_lvl_r[0] & ~pin_lvl_nxt[0];
	assign clear_ok = pin_lvl_r[1];
	assign ext_busy = ~pin_lvl_r[2];

	// Register decode.
	logic [2:0] page;
	logic [4:0] tgt;
	logic [N-1:0] tmask;
	logic wr_in;
	logic wr_trim;
	logic wr_gain;
	logic wr_off;
	logic wr_ctrl;
	logic wr_sel0;
	logic wr_sel1;
	logic wr_sel_all;
	logic wr_ofs0;
	logic wr_ofs1;
	logic [N-1:0] we_in_a;
	logic [N-1:0] we_in_b;
	logic [N-1:0] set_a;
	logic [N-1:0] set_b;

	function automatic logic [N-1:0] target_mask(input logic [4:0] t);
		logic [N-1:0] m;
		m = '0;
		if (!t[4]) begin
			m[t[3:0]] = 1'b1;
		end else if (t == dcd_pkg::TGT_ALL) begin
			m = '1;
		end else if (t == dcd_pkg::TGT_G0) begin
			m = {{G{1'b0}}, {G{1'b1}}};
		end else if (t == dcd_pkg::TGT_G1) begin
			m = {{G{1'b1}}, {G{1'b0}}};
		end else if (t[4:3] == dcd_pkg::TGT_PAIR) begin
			m[{1'b0, t[2:0]}] = 1'b1;
			m[{1'b1, t[2:0]}] = 1'b1;
		end
		return m;
	endfunction

	function automatic logic [dcd_pkg::CH_W-1:0] first_set(
		input logic [N-1:0] v);
		logic [dcd_pkg::CH_W-1:0] idx;
		idx = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (v[k]) begin
				idx = dcd_pkg::CH_W'(k);
			end
		end
		return idx;
	endfunction

	assign page = reg_addr[7:5];
	assign tgt = reg_addr[4:0];
	assign tmask = target_mask(tgt);
	assign wr_in = reg_wr && page == dcd_pkg::PAGE_IN;
	assign wr_gain = reg_wr && page == dcd_pkg::PAGE_GAIN;
	assign wr_off = reg_wr && page == dcd_pkg::PAGE_OFF;
	assign wr_trim = wr_gain | wr_off;
	assign wr_ctrl = reg_wr && reg_addr == dcd_pkg::ADR_CTRL;
	assign wr_sel0 = reg_wr && reg_addr == dcd_pkg::ADR_SEL0;
	assign wr_sel1 = reg_wr && reg_addr == dcd_pkg::ADR_SEL1;
	assign wr_sel_all = reg_wr && reg_addr == dcd_pkg::ADR_SEL_ALL;
	assign wr_ofs0 = reg_wr && reg_addr == dcd_pkg::ADR_OFS0;
	assign wr_ofs1 = reg_wr && reg_addr == dcd_pkg::ADR_OFS1;
	// The one global bank bit steers every targeted channel alike.
	assign we_in_a = {N{wr_in & ~bank_r}} & tmask;
	assign we_in_b = {N{wr_in & bank_r}} & tmask;
	assign set_a = {N{(wr_in | wr_trim) & ~bank_r}} & tmask;
	assign set_b = {N{(wr_in | wr_trim) & bank_r}} & tmask;

	// Recalculation sequencer; bank A work is drained before bank B.
	logic any_pend;
	logic pick_b;
	logic [dcd_pkg::CH_W-1:0] pick_ch;
	logic [N-1:0] take;
	logic start;
	logic store;
	logic [N-1:0] store_a;
	logic [N-1:0] store_b;
	logic busy_local;
	logic busy_all;
	logic load_req;
	logic do_load;

	assign any_pend = |pend_a_r | |pend_b_r;
	assign pick_b = ~|pend_a_r;
	assign pick_ch = first_set(pick_b ? pend_b_r : pend_a_r);
	assign start = state_r == dcd_pkg::ST_IDLE && any_pend;
	assign take = start ? (N'(1) << pick_ch) : '0;
	// A write landing on the channel being taken keeps its pending bit.
	assign pend_a_nxt = (pend_a_r & ~(take & {N{~pick_b}})) | set_a;
	assign pend_b_nxt = (pend_b_r & ~(take & {N{pick_b}})) | set_b;
	assign store = state_r == dcd_pkg::ST_STORE;
	assign store_a = {N{store & ~op_bank_r}} & (N'(1) << op_ch_r);
	assign store_b = {N{store & op_bank_r}} & (N'(1) << op_ch_r);
	assign busy_local = any_pend || state_r != dcd_pkg::ST_IDLE ||
		sel_cnt_r != '0;
	assign busy_all = busy_local | ext_busy;
	assign busy_n_o = 1'b0;
	assign busy_n_oe = busy_local;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= dcd_pkg::ST_IDLE;
			pend_a_r <= '0;
			pend_b_r <= '0;
		end else begin
			pend_a_r <= pend_a_nxt;
			pend_b_r <= pend_b_nxt;
			case (state_r)
				dcd_pkg::ST_IDLE: begin
					if (any_pend) begin
						state_r <= dcd_pkg::ST_CALC;
					end
				end
				dcd_pkg::ST_CALC: begin
					state_r <= dcd_pkg::ST_STORE;
				end
				default: begin
					state_r <= dcd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Operands are latched at the start, so later writes only requeue.
	always_ff @(posedge ref_clk) begin
		if (start) begin
			op_ch_r <= pick_ch;
			op_bank_r <= pick_b;
			op_in_r <= pick_b ? input_bank_b[pick_ch] : input_bank_a[pick_ch];
			op_gain_r <= gain_r[pick_ch];
			op_off_r <= offset_r[pick_ch];
		end
		if (state_r == dcd_pkg::ST_CALC) begin
			res_r <= cal_out;
		end
	end

	// Only this one arithmetic unit exists for all channels.
	dcd_cal_unit u_cal (
		.in_code(op_in_r),
		.gain_code(op_gain_r),
		.off_code(op_off_r),
		.cal_code(cal_out)
	);

	// Load strobe: edges are remembered while busy, a held low level reloads.
	assign load_req = load_pend_r | ~pin_lvl_r[0];
	assign do_load = load_req & ~busy_all & clear_ok;
	assign load_pend_nxt = clear_ok & (load_fall | (load_pend_r & ~do_load));

	// Global configuration registers.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_r <= 1'b0;
			group0_source_select <= dcd_pkg::SEL_DEF;
			group1_source_select <= dcd_pkg::SEL_DEF;
			ofs0_r <= dcd_pkg::OFS_DEF;
			ofs1_r <= dcd_pkg::OFS_DEF;
			sel_cnt_r <= '0;
			load_pend_r <= 1'b0;
		end else begin
			load_pend_r <= load_pend_nxt;
			if (wr_ctrl) begin
				bank_r <= reg_wdata[dcd_pkg::CTRL_BANK_BIT];
			end
			if (wr_sel_all) begin
				group0_source_select <= {G{reg_wdata[0]}};
				group1_source_select <= {G{reg_wdata[0]}};
			end else if (wr_sel0) begin
				group0_source_select <= reg_wdata[G-1:0];
			end else if (wr_sel1) begin
				group1_source_select <= reg_wdata[G-1:0];
			end
			if (wr_ofs0) begin
				ofs0_r <= reg_wdata[dcd_pkg::OFS_W-1:0];
			end
			if (wr_ofs1) begin
				ofs1_r <= reg_wdata[dcd_pkg::OFS_W-1:0];
			end
			if (wr_sel_all | wr_sel0 | wr_sel1) begin
				sel_cnt_r <= dcd_pkg::SEL_CNT_W'(dcd_pkg::SEL_BUSY_CYC);
			end else if (sel_cnt_r != '0) begin
				sel_cnt_r <= sel_cnt_r - 1'b1;
			end
		end
	end

	// Per-channel registers.
	logic [N-1:0] src_b;
	assign src_b = {group1_source_select, group0_source_select};

	for (genvar i = 0; i < N; i++) begin : g_ch
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				input_bank_a[i] <= dcd_pkg::IN_DEF;
				input_bank_b[i] <= dcd_pkg::IN_DEF;
				gain_r[i] <= dcd_pkg::GAIN_DEF;
				offset_r[i] <= dcd_pkg::OFF_DEF;
				calibrated_bank_a[i] <= dcd_pkg::IN_DEF;
				calibrated_bank_b[i] <= dcd_pkg::IN_DEF;
				dac_r[i] <= dcd_pkg::IN_DEF;
				chg_a_r[i] <= 1'b0;
				chg_b_r[i] <= 1'b0;
			end else begin
				if (we_in_a[i]) begin
					input_bank_a[i] <= reg_wdata[W-1:0];
				end
				if (we_in_b[i]) begin
					input_bank_b[i] <= reg_wdata[W-1:0];
				end
				if (wr_gain && tmask[i]) begin
					gain_r[i] <= reg_wdata[W-1:0];
				end
				if (wr_off && tmask[i]) begin
					offset_r[i] <= reg_wdata[W-1:0];
				end
				// Calibrated words are written by the sequencer alone.
				if (store_a[i]) begin
					calibrated_bank_a[i] <= res_r;
				end
				if (store_b[i]) begin
					calibrated_bank_b[i] <= res_r;
				end
				// A fresh result in the load cycle stays marked as changed.
				chg_a_r[i] <= (chg_a_r[i] & ~do_load) | store_a[i];
				chg_b_r[i] <= (chg_b_r[i] & ~do_load) | store_b[i];
				if (do_load && (src_b[i] ? chg_b_r[i] : chg_a_r[i])) begin
					dac_r[i] <= src_b[i] ? calibrated_bank_b[i] :
						calibrated_bank_a[i];
				end
			end
		end
		assign dac_code[i*W +: W] = dac_r[i];
	end

	// Read path: calibrated and DAC registers are deliberately absent.
	logic [dcd_pkg::CH_W-1:0] rd_ch;
	logic rd_one;
	logic [DW-1:0] status;
	logic [DW-1:0] rd_val;

	assign rd_ch = tgt[3:0];
	assign rd_one = ~tgt[4];
	assign status = DW'({~ext_busy ? 1'b0 : 1'b1, ~clear_ok, load_pend_r,
		init_done, busy_local});
	assign rd_val =
		(reg_addr == dcd_pkg::ADR_CTRL) ? DW'(bank_r) :
		(reg_addr == dcd_pkg::ADR_SEL0) ? DW'(group0_source_select) :
		(reg_addr == dcd_pkg::ADR_SEL1) ? DW'(group1_source_select) :
		(reg_addr == dcd_pkg::ADR_OFS0) ? DW'(ofs0_r) :
		(reg_addr == dcd_pkg::ADR_OFS1) ? DW'(ofs1_r) :
		(reg_addr == dcd_pkg::ADR_STATUS) ? status :
		(page == dcd_pkg::PAGE_IN && rd_one) ?
			DW'(bank_r ? input_bank_b[rd_ch] : input_bank_a[rd_ch]) :
		(page == dcd_pkg::PAGE_GAIN && rd_one) ? DW'(gain_r[rd_ch]) :
		(page == dcd_pkg::PAGE_OFF && rd_one) ? DW'(offset_r[rd_ch]) :
		'0;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata_r <= '0;
		end else begin
			reg_rdata_r <= reg_rd ? rd_val : '0;
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign group0_offset_code = ofs0_r;
	assign group1_offset_code = ofs1_r;

	dcd_out_stage #(
		.INIT_CYCLES(INIT_CYCLES)
	) u_out (
		.ref_clk(ref_clk),
		.rst(rst),
		.dac_flat(dac_code),
		.ofs0(ofs0_r),
		.ofs1(ofs1_r),
		.clear_ok(clear_ok),
		.out_level(out_level),
		.out_drive(out_drive),
		.init_done(init_done)
	);
endmodule

// >>> dcd_datapath_bench.sv
// Self-checking bench of the calibration datapath.
module dcd_datapath_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic load_strobe_n = 1'b1, clear_n = 1'b1, peer_go = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic busy_n_o, busy_n_oe, out_drive, peer_oe;
	logic [255:0] dac_code;
	logic [287:0] out_level;
	logic [13:0] ofs0, ofs1;
	int error_cnt = 0, comparisons = 0, n;
	// The wire has a pull-up, so it reads high once every party lets go.
	wire logic busy_wire = !((busy_n_oe && !busy_n_o) || peer_oe);
	dcd_datapath #(.INIT_CYCLES(20)) dcd_datapath_inst (.ref_clk(ref_clk),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.load_strobe_n(load_strobe_n), .clear_n(clear_n),
		.busy_n_i(busy_wire), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe),
		.dac_code(dac_code), .out_level(out_level), .out_drive(out_drive),
		.group0_offset_code(ofs0), .group1_offset_code(ofs1));
	dcd_busy_peer dcd_busy_peer_inst (.ref_clk(ref_clk), .hold_go(peer_go),
		.hold_len(8'h1e), .pull_oe(peer_oe));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] dac(input int i);
		return dac_code[16*i+:16];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			#1;
			if (busy_n_oe === 1'b0 && busy_wire === 1'b1)
				break;
			if (i == 299)
				chk(1'b1, 1'b0);
		end
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic pulse();
		@(posedge ref_clk);
		load_strobe_n <= 1'b0;
		// A one-cycle pulse never lets the last two sync stages agree.
		repeat (3) @(posedge ref_clk);
		load_strobe_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
	task automatic ld();
		wait_idle();
		pulse();
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1 chk(out_drive, 1'b0);
		repeat (40) @(posedge ref_clk);
		#1 chk(out_drive, 1'b1);
		chk(dac(0), 16'h8000);
		chk(out_level[17:0], 18'h00000);
		rd(dcd_pkg::ADR_OFS1, 16'h2000);
		rd(dcd_pkg::ADR_SEL0, 16'h0000);
		rd(dcd_pkg::ADR_STATUS, 16'h0002);
		chk(busy_n_o, 1'b0);
		wr(8'h40, 16'h1234);
		ld();
		chk(dac(0), 16'h1234);
		chk(dac(1), 16'h8000);
		rd(8'h40, 16'h1234);
		wr(dcd_pkg::ADR_CTRL, 16'h0001);
		wr(8'h41, 16'h4000);
		wr(8'h40, 16'h2222);
		wr(dcd_pkg::ADR_SEL0, 16'h0002);
		ld();
		chk(dac(1), 16'h4000);
		chk(dac(0), 16'h1234);
		// Trims are written only once both errors are known.
		wr(8'h61, 16'h7fff);
		wr(8'h81, 16'h9000);
		ld();
		chk(dac(1), 16'h3000);
		wr(8'h61, 16'hffff);
		wr(8'h81, 16'hffff);
		wr(8'h41, 16'hffff);
		ld();
		chk(dac(1), 16'hffff);
		wr(8'h81, 16'h0000);
		wr(8'h41, 16'h0000);
		ld();
		chk(dac(1), 16'h0000);
		wr(dcd_pkg::ADR_SEL_ALL, 16'h0001);
		rd(dcd_pkg::ADR_SEL0, 16'h00ff);
		rd(dcd_pkg::ADR_SEL1, 16'h00ff);
		ld();
		chk(dac(0), 16'h1234);
		wr(dcd_pkg::ADR_SEL_ALL, 16'h0000);
		rd(dcd_pkg::ADR_SEL1, 16'h0000);
		wr(dcd_pkg::ADR_OFS0, 16'h1000);
		rd(dcd_pkg::ADR_OFS0, 16'h1000);
		repeat (4) @(posedge ref_clk);
		#1 chk(out_level[17:0], 18'h01234 - 18'h04000);
		chk(ofs1, 14'h2000);
		@(posedge ref_clk);
		clear_n <= 1'b0;
		wr(dcd_pkg::ADR_CTRL, 16'h0000);
		wr(8'h40, 16'h5555);
		ld();
		chk(out_drive, 1'b0);
		@(posedge ref_clk);
		clear_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1 chk(out_drive, 1'b1);
		chk(dac(0), 16'h1234);
		ld();
		chk(dac(0), 16'h5555);
		wr(8'h42, 16'h7777);
		wait_idle();
		peer_go <= 1'b1;
		@(posedge ref_clk);
		peer_go <= 1'b0;
		pulse();
		chk(dac(2), 16'h8000);
		repeat (30) @(posedge ref_clk);
		#1 chk(dac(2), 16'h7777);
		rd(8'h07, 16'h0000);
		rd(8'hc0, 16'h0000);
		wr(8'h50, 16'h6000);
		n = 0;
		#1;
		while (busy_n_oe === 1'b1 && n < 200) begin
			n++;
			@(posedge ref_clk);
			#1;
		end
		chk(n[17:0], 18'd48);
		ld();
		chk(dac(15), 16'h6000);
		chk(dac(0), 16'h6000);
		wr(8'h5a, 16'h1000);
		ld();
		chk(dac(2), 16'h1000);
		chk(dac(10), 16'h1000);
		chk(dac(3), 16'h6000);
		stop_test();
	end
endmodule

// >>> dcd_datapath_properties.sv
// Concurrent checks on the ports of the calibration datapath.
module dcd_datapath_props #(
	parameter int INIT_CYCLES = dcd_pkg::INIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [dcd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dcd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dcd_pkg::DATA_W-1:0] reg_rdata,
	input wire logic clear_n,
	input wire logic busy_n_oe,
	input wire logic [dcd_pkg::CH_N*dcd_pkg::CODE_W-1:0] dac_code,
	input wire logic [dcd_pkg::CH_N*dcd_pkg::LVL_W-1:0] out_level,
	input wire logic out_drive,
	input wire logic [dcd_pkg::OFS_W-1:0] group0_offset_code
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [dcd_pkg::DATA_W-1:0] wdata_q;
	wire logic [2:0] page = reg_addr[7:5];
	wire logic trim_wr = reg_wr && !reg_addr[4] && (page == dcd_pkg::PAGE_IN
		|| page == dcd_pkg::PAGE_GAIN || page == dcd_pkg::PAGE_OFF);
	wire logic sel_wr = reg_wr && (reg_addr == dcd_pkg::ADR_SEL0 ||
		reg_addr == dcd_pkg::ADR_SEL1);
	always_ff @(posedge ref_clk) begin
		wdata_q <= reg_wdata;
	end
	property p_calc_start;
		trim_wr |=> busy_n_oe;
	endproperty
	a_calc_start: assert property (p_calc_start)
		else $error("no busy after write");
	// One channel through the shared unit takes exactly three cycles.
	property p_one_chan;
		trim_wr && !busy_n_oe ##1 (!reg_wr)[*3] |=> !busy_n_oe;
	endproperty
	a_one_chan: assert property (p_one_chan)
		else $error("single recalc too long");
	property p_sel_busy;
		sel_wr |=> busy_n_oe[*8];
	endproperty
	a_sel_busy: assert property (p_sel_busy)
		else $error("select write not busy");
	property p_rd_idle;
		!reg_rd |=> reg_rdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without read");
	property p_unmapped;
		reg_rd && reg_addr == 8'h07 |=> reg_rdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_dac_quiet;
		$changed(dac_code) |-> !$past(busy_n_oe);
	endproperty
	a_dac_quiet: assert property (p_dac_quiet)
		else $error("load during busy");
	property p_clear_quiet;
		(!clear_n)[*7] |=> $stable(dac_code);
	endproperty
	a_clear_quiet: assert property (p_clear_quiet)
		else $error("load in clear");
	property p_clear_hold;
		(!clear_n)[*7] |-> !out_drive && out_level == '0;
	endproperty
	a_clear_hold: assert property (p_clear_hold)
		else $error("output not held");
	property p_ofs_wr;
		reg_wr && reg_addr == dcd_pkg::ADR_OFS0 |=>
			group0_offset_code == wdata_q[dcd_pkg::OFS_W-1:0];
	endproperty
	a_ofs_wr: assert property (p_ofs_wr)
		else $error("offset code not taken");
endmodule

bind dcd_datapath dcd_datapath_props #(.INIT_CYCLES(INIT_CYCLES))
	dcd_datapath_props_inst (.ref_clk(ref_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .clear_n(clear_n),
	.busy_n_oe(busy_n_oe), .dac_code(dac_code), .out_level(out_level),
	.out_drive(out_drive), .group0_offset_code(group0_offset_code));

// >>> dcd_out_stage.sv
// Output hold, initialization timer and offset-referred output levels.
module dcd_out_stage #(
	parameter int INIT_CYCLES = dcd_pkg::INIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [dcd_pkg::CH_N*dcd_pkg::CODE_W-1:0] dac_flat,
	input wire logic [dcd_pkg::OFS_W-1:0] ofs0,
	input wire logic [dcd_pkg::OFS_W-1:0] ofs1,
	input wire logic clear_ok,
	output logic [dcd_pkg::CH_N*dcd_pkg::LVL_W-1:0] out_level,
	output logic out_drive,
	output logic init_done
);
	localparam int W = dcd_pkg::CODE_W;
	localparam int LW = dcd_pkg::LVL_W;
	localparam logic [dcd_pkg::INIT_CNT_W-1:0] INIT_LAST =
		dcd_pkg::INIT_CNT_W'(INIT_CYCLES - 1);
	logic [dcd_pkg::INIT_CNT_W-1:0] init_cnt_r;
	logic init_done_r;
	logic drive_r;
	logic drive_nxt;
	logic [LW-1:0] ofs0_scaled;
	logic [LW-1:0] ofs1_scaled;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			init_cnt_r <= '0;
			init_done_r <= 1'b0;
		end else if (!init_done_r) begin
			init_done_r <= init_cnt_r == INIT_LAST;
			init_cnt_r <= init_cnt_r + 1'b1;
		end
	end

	// Outputs sit at signal ground until both conditions release them.
	assign drive_nxt = init_done_r & clear_ok;
	assign ofs0_scaled = LW'(ofs0) << dcd_pkg::OFS_SHIFT;
	assign ofs1_scaled = LW'(ofs1) << dcd_pkg::OFS_SHIFT;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drive_r <= 1'b0;
		end else begin
			drive_r <= drive_nxt;
		end
	end

	for (genvar i = 0; i < dcd_pkg::CH_N; i++) begin : g_lvl
		logic [LW-1:0] lvl_r;
		logic [LW-1:0] code;
		assign code = LW'(dac_flat[i*W +: W]);
		always_ff @(posedge ref_clk) begin
			if (rst || !drive_nxt) begin
				lvl_r <= '0;
			end else if (i < dcd_pkg::GRP_N) begin
				lvl_r <= code - ofs0_scaled;
			end else begin
				lvl_r <= code - ofs1_scaled;
			end
		end
		assign out_level[i*LW +: LW] = lvl_r;
	end

	assign out_drive = drive_r;
	assign init_done = init_done_r;
endmodule

// >>> dcd_pkg.sv
// Constants, register map and types of the DAC channel calibration datapath.
package dcd_pkg;
	localparam int CH_N = 16;
	localparam int GRP_N = 8;
	localparam int CH_W = 4;
	// Set CODE_W to 14 for the narrow variant; defaults and scaling follow.
	localparam int CODE_W = 16;
	localparam int OFS_W = 14;
	localparam int OFS_SHIFT = CODE_W - OFS_W;
	localparam int LVL_W = CODE_W + 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [CODE_W-1:0] IN_DEF = {1'b1, {(CODE_W - 1){1'b0}}};
	localparam logic [CODE_W-1:0] GAIN_DEF = {CODE_W{1'b1}};
	localparam logic [CODE_W-1:0] OFF_DEF = {1'b1, {(CODE_W - 1){1'b0}}};
	localparam logic [OFS_W-1:0] OFS_DEF = 14'h2000;
	localparam logic [GRP_N-1:0] SEL_DEF = 8'h00;
	localparam logic [2:0] PIN_IDLE = 3'h5;
	localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADR_SEL0 = 8'h01;
	localparam logic [ADDR_W-1:0] ADR_SEL1 = 8'h02;
	localparam logic [ADDR_W-1:0] ADR_OFS0 = 8'h03;
	localparam logic [ADDR_W-1:0] ADR_OFS1 = 8'h04;
	localparam logic [ADDR_W-1:0] ADR_SEL_ALL = 8'h05;
	localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h06;
	localparam logic [2:0] PAGE_IN = 3'h2;
	localparam logic [2:0] PAGE_GAIN = 3'h3;
	localparam logic [2:0] PAGE_OFF = 3'h4;
	localparam logic [4:0] TGT_ALL = 5'h10;
	localparam logic [4:0] TGT_G0 = 5'h11;
	localparam logic [4:0] TGT_G1 = 5'h12;
	localparam logic [1:0] TGT_PAIR = 2'h3;
	localparam int CTRL_BANK_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_INIT_BIT = 1;
	localparam int STAT_LOAD_BIT = 2;
	localparam int STAT_CLR_BIT = 3;
	localparam int STAT_EXT_BIT = 4;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SEL_BUSY_NS = 600;
	localparam int SEL_BUSY_CYC = (SEL_BUSY_NS / CLK_PERIOD_NS < 1) ? 1 :
		SEL_BUSY_NS / CLK_PERIOD_NS;
	localparam int SEL_CNT_W = 6;
	localparam int INIT_TIME_US = 300;
	localparam int INIT_CYC = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int INIT_CNT_W = 24;
	typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_STORE} dcd_seq_t;
endpackage
